// File: design/etm_pkg.sv
// constants shared by the transmit dma fifo monitor and its fifo storage
// assumes a wishbone slave with an 8-bit byte address and 32-bit data
package etm_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CUR_ADDR = 8'h40;
	localparam logic [7:0] OFS_BYTES_LEFT = 8'h44;
	localparam logic [7:0] OFS_TIMEOUT = 8'h48;
	localparam logic [7:0] OFS_FIFO_STATE = 8'h4c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h50;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h54;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h58;
	localparam logic [7:0] OFS_THRESHOLD = 8'h5c;

	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam int COUNT_W = 12;
	localparam int TMO_W = 16;
	localparam int PTR_W = 5;
	localparam int LVL_W = 6;
	localparam int IRQ_W = 2;

	// reset values and the byte count of one word
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [11:0] RST_COUNT = 12'h000;
	localparam logic [15:0] RST_TIMEOUT = 16'h0000;
	localparam logic [5:0] RST_THRESHOLD = 6'h10;
	localparam logic [11:0] WORD_BYTES = 12'h004;

	// fifo state register fields
	localparam int ST_FREE_LSB = 24;
	localparam int ST_DMA_PTR_LSB = 16;
	localparam int ST_IO_PTR_LSB = 8;
	localparam int ST_DELAY_BIT = 3;
	localparam int ST_ENTRY_BIT = 2;
	localparam int ST_FULL_BIT = 1;
	localparam int ST_EMPTY_BIT = 0;

	// interrupt status, clear and enable layout
	localparam int IRQ_TIMEOUT_BIT = 0;
	localparam int IRQ_THRESH_BIT = 1;
endpackage : etm_pkg

// File: design/etm_fifo_mem.sv
// storage array of the transmit fifo, one write port and one registered read port
// assumes the caller handles pointers, full and empty
`timescale 1ns/1ps
module etm_fifo_mem
	import etm_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int ADDR_BITS = 5
) (
	// clock
	input wire logic clk_i,
	// write port
	input wire logic wr_en_i,
	input wire logic [ADDR_BITS-1:0] wr_addr_i,
	input wire logic [WIDTH-1:0] wr_data_i,
	// read port
	input wire logic [ADDR_BITS-1:0] rd_addr_i,
	output logic [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem [0:(1<<ADDR_BITS)-1];

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	// read of a word written in the same cycle returns the old word
	always_ff @(posedge clk_i) begin
		rd_data_o <= mem[rd_addr_i];
	end
endmodule : etm_fifo_mem

// File: design/etm_tx_monitor.sv
// transmit dma channel status: bus address, remaining bytes, fifo and entry timeout
// assumes the dma engine pushes words and presents its bus address, and the mac side pops words
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module etm_tx_monitor
	import etm_pkg::*;
#(
	parameter int FIFO_PTR_W = PTR_W,
	parameter logic [LVL_W-1:0] THRESHOLD_RESET = RST_THRESHOLD
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [SEL_W-1:0] wb_sel_i,
	input wire logic [DAT_W-1:0] wb_dat_i,
	output logic [DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// dma side
	input wire logic dma_run_i,
	input wire logic [DAT_W-1:0] dma_bus_addr_i,
	input wire logic dma_len_load_i,
	input wire logic [COUNT_W-1:0] dma_len_i,
	input wire logic dma_push_i,
	input wire logic [DAT_W-1:0] dma_push_data_i,
	output logic dma_push_ready_o,
	// mac transmit side
	input wire logic io_pop_i,
	output logic io_valid_o,
	output logic [DAT_W-1:0] io_data_o,
	// interrupt
	output logic irq_o
);
	localparam int DEPTH = 1 << FIFO_PTR_W;
	localparam logic [LVL_W-1:0] DEPTH_LVL = LVL_W'(DEPTH);
	localparam logic [LVL_W-1:0] LVL_ZERO = '0;
	localparam logic [FIFO_PTR_W-1:0] PTR_ONE = FIFO_PTR_W'(1);
	localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);
	localparam logic [TMO_W-1:0] TMO_ONE = TMO_W'(1);
	localparam logic [TMO_W-1:0] TMO_ZERO = '0;

	// register file
	logic [DAT_W-1:0] cur_bus_addr;
	logic [COUNT_W-1:0] bytes_left;
	logic [TMO_W-1:0] timeout_init_value;
	logic [IRQ_W-1:0] mac_irq_status_reg;
	logic [IRQ_W-1:0] mac_irq_enable_reg;
	logic [LVL_W-1:0] entry_threshold;

	// fifo state
	logic [FIFO_PTR_W-1:0] dma_ptr;
	logic [FIFO_PTR_W-1:0] io_ptr;
	logic [FIFO_PTR_W-1:0] next_io_ptr;
	logic [LVL_W-1:0] fill_level;
	logic [LVL_W-1:0] next_fill_level;
	logic head_stale;
	logic fifo_full;
	logic fifo_empty;
	logic push_take;
	logic pop_take;
	logic entry_reached;
	logic entry_reached_q;

	// timeout state
	logic [TMO_W-1:0] tmo_count;
	logic [TMO_W-1:0] next_tmo_count;
	logic delay_flag;
	logic tmo_expire;

	// bus decode
	logic bus_req;
	logic bus_wr;
	logic [DAT_W-1:0] byte_mask;
	logic [DAT_W-1:0] rd_word;
	logic [DAT_W-1:0] fifo_state_word;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_clear;
	logic wr_timeout;
	logic wr_irq_enable;
	logic wr_threshold;
	logic wr_irq_clear;

	// wishbone: ack one cycle after the request, write lands on the acked edge
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign bus_wr = bus_req & wb_we_i & wb_ack_o;

	genvar gb;
	generate
		for (gb = 0; gb < SEL_W; gb++) begin : g_mask
			assign byte_mask[gb*8 +: 8] = {8{wb_sel_i[gb]}};
		end
	endgenerate

	// one write strobe per register; writes to read-only or unmapped offsets are acked and dropped
	// the timeout register takes its byte lanes from the mask, the narrow ones use lane 0 only
	always_comb begin
		wr_timeout = 1'b0;
		wr_irq_enable = 1'b0;
		wr_threshold = 1'b0;
		wr_irq_clear = 1'b0;
		if (bus_wr) begin
			case (wb_adr_i)
				OFS_TIMEOUT: wr_timeout = 1'b1;
				OFS_IRQ_ENABLE: wr_irq_enable = wb_sel_i[0];
				OFS_THRESHOLD: wr_threshold = wb_sel_i[0];
				OFS_IRQ_CLEAR: wr_irq_clear = wb_sel_i[0];
				default: wr_timeout = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= RST_WORD;
		end else if (bus_req & ~wb_ack_o & ~wb_we_i) begin
			wb_dat_o <= rd_word;
		end
	end

	// fifo state word; fields not assigned stay zero
	always_comb begin
		fifo_state_word = RST_WORD;
		fifo_state_word[ST_FREE_LSB +: LVL_W] = DEPTH_LVL - fill_level;
		fifo_state_word[ST_DMA_PTR_LSB +: FIFO_PTR_W] = dma_ptr;
		fifo_state_word[ST_IO_PTR_LSB +: FIFO_PTR_W] = io_ptr;
		fifo_state_word[ST_DELAY_BIT] = delay_flag;
		fifo_state_word[ST_ENTRY_BIT] = entry_reached;
		fifo_state_word[ST_FULL_BIT] = fifo_full;
		fifo_state_word[ST_EMPTY_BIT] = fifo_empty;
	end

	// read mux; narrow registers are zero extended, unmapped reads give zero
	always_comb begin
		rd_word = RST_WORD;
		case (wb_adr_i)
			OFS_CUR_ADDR: rd_word = cur_bus_addr;
			OFS_BYTES_LEFT: rd_word = {{(DAT_W-COUNT_W){1'b0}}, bytes_left};
			OFS_TIMEOUT: rd_word = {{(DAT_W-TMO_W){1'b0}}, timeout_init_value};
			OFS_FIFO_STATE: rd_word = fifo_state_word;
			OFS_IRQ_STATUS: rd_word = {{(DAT_W-IRQ_W){1'b0}}, mac_irq_status_reg};
			OFS_IRQ_ENABLE: rd_word = {{(DAT_W-IRQ_W){1'b0}}, mac_irq_enable_reg};
			OFS_THRESHOLD: rd_word = {{(DAT_W-LVL_W){1'b0}}, entry_threshold};
			default: rd_word = RST_WORD;
		endcase
	end

	// software writable registers, byte lanes honoured
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timeout_init_value <= RST_TIMEOUT;
		end else if (wr_timeout) begin
			timeout_init_value <= (timeout_init_value & ~byte_mask[TMO_W-1:0]) |
				(wb_dat_i[TMO_W-1:0] & byte_mask[TMO_W-1:0]);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mac_irq_enable_reg <= '0;
		end else if (wr_irq_enable) begin
			mac_irq_enable_reg <= wb_dat_i[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			entry_threshold <= THRESHOLD_RESET;
		end else if (wr_threshold) begin
			entry_threshold <= wb_dat_i[LVL_W-1:0];
		end
	end

	// dma progress registers
	// the copy trails the bus by one clock, which is fine for software polling
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_bus_addr <= RST_WORD;
		end else if (dma_run_i) begin
			cur_bus_addr <= dma_bus_addr_i;
		end
	end

	// saturates at zero so a stray extra word cannot wrap the count
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bytes_left <= RST_COUNT;
		end else if (dma_len_load_i) begin
			bytes_left <= dma_len_i;
		end else if (push_take) begin
			bytes_left <= (bytes_left > WORD_BYTES) ? bytes_left - WORD_BYTES : RST_COUNT;
		end
	end

	// fifo control
	assign fifo_full = (fill_level == DEPTH_LVL);
	assign fifo_empty = (fill_level == LVL_ZERO);
	assign dma_push_ready_o = ~fifo_full;
	assign push_take = dma_push_i & ~fifo_full;
	// the head word needs one more cycle when it was written into the slot being read
	assign io_valid_o = ~fifo_empty & ~head_stale;
	assign pop_take = io_pop_i & io_valid_o;
	assign next_io_ptr = pop_take ? io_ptr + PTR_ONE : io_ptr;
	assign entry_reached = (fill_level >= entry_threshold);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dma_ptr <= '0;
			io_ptr <= '0;
		end else begin
			if (push_take) begin
				dma_ptr <= dma_ptr + PTR_ONE;
			end
			io_ptr <= next_io_ptr;
		end
	end

	// a push and a pop in the same cycle leave the level where it is
	always_comb begin
		next_fill_level = fill_level;
		if (push_take & ~pop_take) begin
			next_fill_level = fill_level + LVL_ONE;
		end else if (pop_take & ~push_take) begin
			next_fill_level = fill_level - LVL_ONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fill_level <= '0;
		end else begin
			fill_level <= next_fill_level;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			head_stale <= 1'b0;
		end else begin
			head_stale <= push_take && (dma_ptr == next_io_ptr);
		end
	end

	etm_fifo_mem #(
		.WIDTH(DAT_W),
		.ADDR_BITS(FIFO_PTR_W)
	) u_mem (
		.clk_i(clk_i),
		.wr_en_i(push_take),
		.wr_addr_i(dma_ptr),
		.wr_data_i(dma_push_data_i),
		.rd_addr_i(next_io_ptr),
		.rd_data_o(io_data_o)
	);

	// entry timeout: counts down once per clock while entries wait, reloads on pop
	always_comb begin
		next_tmo_count = tmo_count;
		if (pop_take || fifo_empty) begin
			next_tmo_count = timeout_init_value;
		end else if (tmo_count != TMO_ZERO) begin
			next_tmo_count = tmo_count - TMO_ONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tmo_count <= RST_TIMEOUT;
		end else begin
			tmo_count <= next_tmo_count;
		end
	end

	// a count of zero still waiting means more than the programmed cycles have passed
	assign tmo_expire = ~fifo_empty & ~pop_take & ~delay_flag & (tmo_count == TMO_ZERO);

	// delay flag holds until the next pop; it fires once per stall
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			delay_flag <= 1'b0;
		end else if (tmo_expire) begin
			delay_flag <= 1'b1;
		end else if (pop_take) begin
			delay_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			entry_reached_q <= 1'b0;
		end else begin
			entry_reached_q <= entry_reached;
		end
	end

	// interrupt status: events win over a clear in the same cycle
	always_comb begin
		irq_events = '0;
		irq_events[IRQ_TIMEOUT_BIT] = tmo_expire;
		irq_events[IRQ_THRESH_BIT] = entry_reached & ~entry_reached_q;
	end

	assign irq_clear = wr_irq_clear ? wb_dat_i[IRQ_W-1:0] : '0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mac_irq_status_reg <= '0;
		end else begin
			mac_irq_status_reg <= (mac_irq_status_reg & ~irq_clear) | irq_events;
		end
	end

	assign irq_o = |(mac_irq_status_reg & mac_irq_enable_reg);
endmodule : etm_tx_monitor

// File: sim/etm_tx_monitor_chk.sv
// port checker for the transmit monitor
// assumes a bind onto every etm_tx_monitor instance
`timescale 1ns/1ps
module etm_tx_monitor_chk
	import etm_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [DAT_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	// fifo sides
	input wire logic dma_run_i,
	input wire logic [DAT_W-1:0] dma_bus_addr_i,
	input wire logic dma_push_i,
	input wire logic dma_push_ready_o,
	input wire logic io_pop_i,
	input wire logic io_valid_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic rd;
	assign rd = wb_ack_o && !wb_we_i;
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bus answer wrong");
	property p_cnt; rd && wb_adr_i == OFS_BYTES_LEFT |-> wb_dat_o[31:12] == 20'h0_0000; endproperty
	a_cnt: assert property (p_cnt) else $error("count reserved bits set");
	property p_tmo; rd && wb_adr_i == OFS_TIMEOUT |-> wb_dat_o[31:16] == 16'h0000; endproperty
	a_tmo: assert property (p_tmo) else $error("timeout reserved bits set");
	property p_srsv; rd && wb_adr_i == OFS_FIFO_STATE |-> (wb_dat_o & 32'hc0e0_e0f0) == 32'h0000_0000; endproperty
	a_srsv: assert property (p_srsv) else $error("state reserved bits set");
	property p_empty; rd && wb_adr_i == OFS_FIFO_STATE && wb_dat_o[0]
		|-> wb_dat_o[29:24] == 6'h20 && !wb_dat_o[1] && wb_dat_o[20:16] == wb_dat_o[12:8]; endproperty
	a_empty: assert property (p_empty) else $error("empty state inconsistent");
	property p_full; rd && wb_adr_i == OFS_FIFO_STATE && wb_dat_o[1]
		|-> wb_dat_o[29:24] == 6'h00 && wb_dat_o[20:16] == wb_dat_o[12:8]; endproperty
	a_full: assert property (p_full) else $error("full state inconsistent");
	property p_addr; rd && wb_adr_i == OFS_CUR_ADDR && $past(dma_run_i, 2) && $stable(dma_bus_addr_i)
		&& $past(dma_bus_addr_i) == $past(dma_bus_addr_i, 2) |-> wb_dat_o == dma_bus_addr_i; endproperty
	a_addr: assert property (p_addr) else $error("address not mirrored");
	property p_refill; !dma_push_ready_o && io_pop_i && io_valid_o |=> dma_push_ready_o; endproperty
	a_refill: assert property (p_refill) else $error("full after pop");
	property p_valid; !io_valid_o && dma_push_i && dma_push_ready_o |-> ##[1:3] io_valid_o; endproperty
	a_valid: assert property (p_valid) else $error("pushed word not offered");
	property p_irq; $fell(irq_o) |-> $past(wb_ack_o && wb_we_i); endproperty
	a_irq: assert property (p_irq) else $error("irq dropped without write");
endmodule : etm_tx_monitor_chk

bind etm_tx_monitor etm_tx_monitor_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.dma_run_i(dma_run_i), .dma_bus_addr_i(dma_bus_addr_i), .dma_push_i(dma_push_i),
	.dma_push_ready_o(dma_push_ready_o), .io_pop_i(io_pop_i), .io_valid_o(io_valid_o), .irq_o(irq_o));

// File: sim/etm_mem_model.sv
// main memory and bus fetch model feeding the transmit fifo a word at a time
// assumes go_i pulses while idle; memory words are the address scrambled by a pattern
`timescale 1ns/1ps
module etm_mem_model (
	// bench control
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic slow_i,
	input wire logic [5:0] words_i,
	input wire logic [31:0] base_i,
	// dma side
	input wire logic dma_push_ready_i,
	output logic dma_run_o,
	output logic [31:0] dma_bus_addr_o,
	output logic dma_len_load_o,
	output logic [11:0] dma_len_o,
	output logic dma_push_o,
	output logic [31:0] dma_push_data_o
);
	logic [5:0] left;
	logic gap;
	always_ff @(posedge clk_i) begin
		dma_len_load_o <= 1'b0;
		if (rst_i) begin
			dma_run_o <= 1'b0;
			dma_push_o <= 1'b0;
			left <= 6'h00;
			gap <= 1'b0;
			dma_bus_addr_o <= 32'h0000_0000;
			dma_len_o <= 12'h000;
			dma_push_data_o <= 32'h0000_0000;
		end else if (go_i && !dma_run_o) begin
			dma_run_o <= 1'b1;
			dma_len_load_o <= 1'b1;
			dma_len_o <= {4'h0, words_i, 2'b00};
			left <= words_i;
			dma_bus_addr_o <= base_i;
		end else if (dma_run_o) begin
			if (dma_push_o && dma_push_ready_i) begin
				// data line is scrambled once taken so a stale word is never mistaken for a push
				dma_push_o <= 1'b0;
				dma_push_data_o <= ~dma_push_data_o;
				left <= left - 6'h01;
				dma_bus_addr_o <= dma_bus_addr_o + 32'h0000_0004;
				gap <= slow_i;
			end else if (!dma_push_o && left == 6'h00) begin
				dma_run_o <= 1'b0;
				dma_bus_addr_o <= ~dma_bus_addr_o;
			end else if (!dma_push_o && !gap) begin
				dma_push_o <= 1'b1;
				dma_push_data_o <= dma_bus_addr_o ^ 32'ha5a5_5a5a;
			end else begin
				gap <= 1'b0;
			end
		end
	end
endmodule : etm_mem_model

// File: sim/tb_top.sv
// self-checking bench: register reads, fifo traffic via the memory model, entry timeout
// assumes the monitor design and the memory model beside it
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; $display("BAD %0t %h %h", $time, a, e); end end
module tb_top
	import etm_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, we = 1'b0, pop = 1'b0, go = 1'b0, slow = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000, base = 32'h0000_0000, b_cur, m_e, x_e, d_e;
	logic [5:0] words = 6'h00;
	logic [31:0] rdat, io_data, bus_addr, pdata;
	logic ack, ready, valid, irq, run, lload, push;
	logic [11:0] len;
	logic [31:0] xq[$], mq[$], dq[$];
	logic [7:0] ofs[8] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h50, 8'h58, 8'h5c, 8'h60};
	logic [31:0] rv[8] = '{0, 0, 0, 32'h2000_0001, 0, 0, 32'h0000_0010, 0};
	int failures = 0, checked = 0, seed = 32'h7c6066aa, n, t0;
	always #12.5 clk_i = ~clk_i;
	etm_tx_monitor u_etm_tx_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dma_run_i(run),
		.dma_bus_addr_i(bus_addr), .dma_len_load_i(lload), .dma_len_i(len), .dma_push_i(push),
		.dma_push_data_i(pdata), .dma_push_ready_o(ready), .io_pop_i(pop), .io_valid_o(valid),
		.io_data_o(io_data), .irq_o(irq));
	etm_mem_model u_etm_mem_model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .slow_i(slow), .words_i(words),
		.base_i(base), .dma_push_ready_i(ready), .dma_run_o(run), .dma_bus_addr_o(bus_addr),
		.dma_len_load_o(lload), .dma_len_o(len), .dma_push_o(push), .dma_push_data_o(pdata));
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			m_e = mq.pop_front();
			x_e = xq.pop_front();
			`CHK(rdat & m_e, x_e)
		end
		if (valid === 1'b1 && pop === 1'b1) begin
			d_e = dq.pop_front();
			`CHK(io_data, d_e)
		end
	end
	task automatic finish_test;
		if (failures == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic tmo;
		failures++;
		finish_test();
	endtask : tmo
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		int k;
		if (!w) begin
			xq.push_back(d & m);
			mq.push_back(m);
		end
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= w ? d : 32'h0000_0000;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) tmo();
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic run_dma(input logic [5:0] w, input logic s);
		b_cur = $random(seed) & 32'hffff_fffc;
		for (int i = 0; i < w; i++) dq.push_back((b_cur + 4 * i) ^ 32'ha5a5_5a5a);
		base <= b_cur;
		words <= w;
		slow <= s;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
	endtask : run_dma
	task automatic pop_n(input int w);
		int k, t;
		k = 0;
		t = 0;
		pop <= 1'b1;
		while (k < w && t < 400) begin
			@(posedge clk_i);
			t++;
			if (valid === 1'b1) k++;
		end
		pop <= 1'b0;
		if (t >= 400) tmo();
	endtask : pop_n
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) wb(1'b0, ofs[i], rv[i], 32'hffff_ffff);
		wb(1'b1, OFS_TIMEOUT, 32'hffff_1234, 0);
		wb(1'b0, OFS_TIMEOUT, 32'h0000_1234, 32'hffff_ffff);
		run_dma(6'd3, 1'b0);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (run === 1'b1 && n < 400);
		if (n >= 400) tmo();
		wb(1'b0, OFS_BYTES_LEFT, 0, 32'hffff_ffff);
		wb(1'b0, OFS_CUR_ADDR, b_cur + 12, 32'hffff_ffff);
		wb(1'b0, OFS_FIFO_STATE, 32'h1d03_0000, 32'hffff_ffff);
		pop_n(3);
		wb(1'b0, OFS_FIFO_STATE, 32'h2003_0301, 32'hffff_ffff);
		wb(1'b1, OFS_TIMEOUT, 32'h0000_0014, 0);
		wb(1'b1, OFS_IRQ_ENABLE, 1, 0);
		run_dma(6'd1, 1'b0);
		t0 = 0;
		n = 0;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
			if (push === 1'b1 && ready === 1'b1) t0 = n;
		end
		if (n >= 100) tmo();
		`CHK(n - t0 inside {[21:24]}, 1'b1)
		wb(1'b0, OFS_FIFO_STATE, 8, 8);
		wb(1'b0, OFS_IRQ_STATUS, 1, 1);
		wb(1'b1, OFS_IRQ_ENABLE, 0, 0);
		`CHK(irq, 1'b0)
		wb(1'b1, OFS_IRQ_ENABLE, 1, 0);
		`CHK(irq, 1'b1)
		wb(1'b1, OFS_IRQ_CLEAR, 1, 0);
		pop_n(1);
		wb(1'b0, OFS_FIFO_STATE, 0, 8);
		wb(1'b1, OFS_TIMEOUT, 32'h0000_ffff, 0);
		run_dma(6'd34, 1'b1);
		n = 0;
		while (ready !== 1'b0 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 400) tmo();
		wb(1'b0, OFS_CUR_ADDR, b_cur + 128, 32'hffff_ffff);
		wb(1'b0, OFS_BYTES_LEFT, 8, 32'hffff_ffff);
		wb(1'b0, OFS_FIFO_STATE, 6, 32'h3f00_0007);
		pop_n(34);
		wb(1'b0, OFS_FIFO_STATE, 32'h2000_0001, 32'h3f00_000f);
		finish_test();
	end
endmodule : tb_top
